// ==== dwell_timer.sv ====
// Purpose: dwell timer counting interval units of 1024 reference clocks
// Assumes: restart pulses on every rate change
// Notes: interval of zero expires after one unit
`timescale 1ns/1ps
`default_nettype none
`include "rate_search_params.svh"
module dwell_timer (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	dwell_if.timer dw
);
	logic [9:0] pre_reg;
	logic [20:0] unit_reg;
	wire unit_tick = pre_reg == `DWELL_UNIT_LAST;
	wire [20:0] unit_plus = unit_reg + 21'h000001;
	// >= so a shrinking interval cannot strand the count
	wire done = unit_tick & (unit_plus >= dw.interval); // R5

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pre_reg <= 10'h000;
			unit_reg <= 21'h000000;
			dw.expire <= 1'b0;
		end
		else
		begin
			dw.expire <= done & ~dw.restart;
			if (dw.restart | done)
			begin
				pre_reg <= 10'h000;
				unit_reg <= 21'h000000;
			end
			else
			begin
				pre_reg <= pre_reg + 10'h001;
				if (unit_tick)
					unit_reg <= unit_plus;
			end
		end
	end
endmodule : dwell_timer
`default_nettype wire

// ==== mgmt_frame_slave.sv ====
// Purpose: management serial frame slave, turns frames into register strobes
// Assumes: mdc far slower than mclk_i, at least 8 mclk per mdc phase
// Notes: needs full 32-bit preamble before every frame
`timescale 1ns/1ps
`default_nettype none
`include "rate_search_params.svh"
module mgmt_frame_slave (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	input wire logic [4:0] phy_addr_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	reg_access_if.frame bus
);
	rate_search_pkg::mgmt_state_t state_reg;
	logic mdc_s1_reg, mdc_s2_reg, mdc_s3_reg, mdio_s1_reg, mdio_s2_reg;
	logic [4:0] phy_s1_reg, phy_s2_reg;
	logic [5:0] ones_reg;
	logic [3:0] cnt_reg;
	logic [15:0] shift_reg;
	logic [4:0] addr_reg;
	logic read_reg;
	wire rise = mdc_s2_reg & ~mdc_s3_reg;
	wire bit_in = mdio_s2_reg;
	wire [12:0] hdr = {shift_reg[11:0], bit_in};
	wire hdr_ok = hdr[12] & (hdr[9:5] == phy_s2_reg);
	wire is_rd = hdr[11:10] == `OP_READ;
	wire is_wr = hdr[11:10] == `OP_WRITE;
	assign bus.addr = addr_reg;
	// strobe is set on the same rise as the last shift, so the word is complete
	assign bus.wdata = shift_reg;

	// pins are asynchronous to mclk_i, two flops before use
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			{mdc_s1_reg, mdc_s2_reg, mdc_s3_reg} <= 3'h0;
			{mdio_s1_reg, mdio_s2_reg} <= 2'h3;
			phy_s1_reg <= 5'h00;
			phy_s2_reg <= 5'h00;
		end
		else
		begin
			{mdc_s1_reg, mdc_s2_reg, mdc_s3_reg} <=
				{mdc_i, mdc_s1_reg, mdc_s2_reg};
			{mdio_s1_reg, mdio_s2_reg} <= {mdio_i, mdio_s1_reg};
			phy_s1_reg <= phy_addr_i;
			phy_s2_reg <= phy_s1_reg;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg <= rate_search_pkg::M_IDLE;
			ones_reg <= 6'h00;
			cnt_reg <= 4'h0;
			shift_reg <= 16'h0000;
			addr_reg <= 5'h00;
			read_reg <= 1'b0;
			mdio_o <= 1'b1;
			mdio_oe_o <= 1'b0;
			bus.rd_stb <= 1'b0;
			bus.wr_stb <= 1'b0;
		end
		else
		begin
			bus.rd_stb <= 1'b0;
			bus.wr_stb <= 1'b0;
			if (rise)
			begin
				case (state_reg)
					rate_search_pkg::M_IDLE:
					begin
						if (bit_in)
							ones_reg <= (ones_reg == `PREAMBLE_ONES) ?
								ones_reg : ones_reg + 6'h01;
						else if (ones_reg == `PREAMBLE_ONES)
						begin
							state_reg <= rate_search_pkg::M_HDR;
							cnt_reg <= 4'h0;
						end
						else
							ones_reg <= 6'h00;
					end
					rate_search_pkg::M_HDR:
					begin
						shift_reg <= {shift_reg[14:0], bit_in};
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == 4'hc)
						begin
							cnt_reg <= 4'h0;
							ones_reg <= 6'h00;
							addr_reg <= hdr[4:0];
							read_reg <= is_rd;
							bus.rd_stb <= hdr_ok & is_rd;
							// frames for other addresses are ignored
							state_reg <= (hdr_ok & (is_rd | is_wr)) ?
								rate_search_pkg::M_TA : rate_search_pkg::M_IDLE;
						end
					end
					rate_search_pkg::M_TA:
					begin
						cnt_reg <= cnt_reg + 4'h1;
						if (cnt_reg == 4'h0)
						begin
							mdio_oe_o <= read_reg;
							mdio_o <= 1'b0;
							shift_reg <= bus.rdata;
						end
						else
						begin
							cnt_reg <= 4'h0;
							state_reg <= rate_search_pkg::M_DATA;
							if (read_reg)
							begin
								mdio_o <= shift_reg[15];
								shift_reg <= {shift_reg[14:0], 1'b0};
							end
						end
					end
					rate_search_pkg::M_DATA:
					begin
						cnt_reg <= cnt_reg + 4'h1;
						shift_reg <= {shift_reg[14:0], read_reg ? 1'b0 : bit_in};
						if (read_reg)
							mdio_o <= shift_reg[15];
						if (cnt_reg == 4'hf)
						begin
							state_reg <= rate_search_pkg::M_IDLE;
							mdio_oe_o <= 1'b0;
							mdio_o <= 1'b1;
							bus.wr_stb <= ~read_reg;
						end
					end
					default:
						state_reg <= rate_search_pkg::M_IDLE;
				endcase
			end
		end
	end
endmodule : mgmt_frame_slave
`default_nettype wire

// ==== mgmt_host_model.sv ====
// Purpose: management host driving serial frames into the block
// Assumes: mdc phase of 10 mclk, line pulled up when released
// Notes: mdc stands low between frames
`timescale 1ns/1ps
`default_nettype none
`include "rate_search_params.svh"
module mgmt_host_model #(
	parameter logic [4:0] PHY = 5'h05
) (
	input wire logic mclk_i,
	input wire logic mdio_i,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o
);
	initial
	begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end
	task automatic half;
		repeat (10) @(posedge mclk_i);
		#1;
	endtask : half
	// read bits are taken at the next rise, before the block moves on
	task automatic frame(input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hffffffff, 2'b01, op, PHY, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--)
		begin
			mdio_o = bits[i];
			mdio_oe_o = !(op == `OP_READ && i < 18);
			half;
			mdc_o = 1'b1;
			if (i < 16)
				rd = {rd[14:0], mdio_i};
			half;
			mdc_o = 1'b0;
		end
		mdio_oe_o = 1'b0;
	endtask : frame
endmodule : mgmt_host_model
`default_nettype wire

// ==== rate_search_if.sv ====
// Purpose: internal carriers between the block's modules
// Assumes: single clock domain
// Notes: strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
	logic wr_stb;
	logic rd_stb;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport frame (output wr_stb, output rd_stb, output addr, output wdata,
		input rdata);
	modport regs (input wr_stb, input rd_stb, input addr, input wdata,
		output rdata);
endinterface : reg_access_if

interface dwell_if;
	logic restart;
	logic [20:0] interval;
	logic expire;
	modport ctrl (output restart, output interval, input expire);
	modport timer (input restart, input interval, output expire);
endinterface : dwell_if
`default_nettype wire

// ==== rate_search_params.svh ====
// Purpose: constants for the rate search and error count block
// Assumes: mclk_i is the reference clock, 200 MHz
// Notes: offsets are management register numbers
// Overview of operation
// R1: two-bit reference frequency code: 00, 01 (reset), 11 valid; 10 reserved.
// R2: eight candidate rate enables; only enabled rates are tried. With no enable bit set, the code still selects rate 7.
// R3: enable bit 7 is the highest rate, bit 0 the lowest.
// R4: 21-bit dwell interval: upper 5 bits in 0x0b[4:0], lower 16 in 0x0c.
// R5: stay at each candidate rate for interval times 1024 reference clocks.
// R6: no lock before wait expires moves search to next lower rate.
// R7: with decoder enabled, count invalid code words including disparity errors.
// R8: in pattern verification mode, count errors of selected test pattern.
// R9: while prbs test pin is high, count prbs pattern errors.
// R10: reading the error counter returns its value, then clears it.
// R11: mode 00 management, 01/10 own search, 11 follow partner search.
// R12: stepping down skips candidate rates whose enable bit is clear.
// R13: reserved bits ignore writes and read their default values.
`ifndef RATE_SEARCH_PARAMS_SVH
`define RATE_SEARCH_PARAMS_SVH
`define ADDR_CTRL_A 5'h0a
`define ADDR_CTRL_B 5'h0b
`define ADDR_INTERVAL_LOW 5'h0c
`define ADDR_RESERVED 5'h0d
`define ADDR_ERROR_COUNT 5'h0e
`define ADDR_VENDOR_STATUS 5'h0f
`define RST_CTRL_A 16'h0800
`define RST_CTRL_B 16'h7fff
`define RST_INTERVAL_LOW 16'hffff
`define RST_RESERVED 16'h3000
`define RST_ERROR_COUNT 16'hfffd
`define RST_VENDOR_STATUS 16'h0205
`define MODE_LSB 12
`define REF_FREQ_LSB 14
`define RATE_EN_LSB 6
`define RESERVED_BIT 5
`define INTERVAL_HI_MSB 4
`define DWELL_UNIT_CYCLES 1024
`define DWELL_UNIT_LAST 10'h3ff
`define PREAMBLE_ONES 6'h20
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`endif

// ==== rate_search_pkg.sv ====
// Purpose: types for the rate search and error count block
// Assumes: nothing
// Notes: one-hot state codes
package rate_search_pkg;
	typedef enum logic [3:0] {
		M_IDLE = 4'h1,
		M_HDR = 4'h2,
		M_TA = 4'h4,
		M_DATA = 4'h8
	} mgmt_state_t;
	typedef enum logic [2:0] {
		S_MGMT = 3'h1,
		S_DWELL = 3'h2,
		S_LOCK = 3'h4
	} search_state_t;
endpackage : rate_search_pkg

// ==== rate_search_top.sv ====
// Purpose: rate search control, dwell timing and error counting
// Assumes: mclk_i is the reference clock; error pulses are on mclk_i
// Notes: registers reached by the management serial frame
`timescale 1ns/1ps
`default_nettype none
`include "rate_search_params.svh"
module rate_search_top (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	input wire logic [4:0] phy_addr_i,
	input wire logic rate_lock_i,
	input wire logic partner_search_en_i,
	input wire logic [2:0] partner_rate_i,
	input wire logic decoder_en_i,
	input wire logic code_err_i,
	input wire logic test_verify_en_i,
	input wire logic pattern_err_i,
	input wire logic prbs_test_pin_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	output logic [1:0] search_ref_freq_code_o,
	output logic [2:0] rate_sel_o,
	output logic mgmt_ctrl_o,
	output logic search_locked_o
);
	reg_access_if bus ();
	dwell_if dw ();
	rate_search_pkg::search_state_t state_reg, state_next;
	logic [1:0] search_enable_mode_reg;
	logic [9:0] ctrl_b_hi_reg;
	logic [4:0] interval_hi_reg;
	logic [15:0] interval_low_reg;
	logic [15:0] err_cnt_reg;
	logic [15:0] rdata_reg;
	logic [2:0] rate_reg, rate_next;
	logic [1:0] lock_s_reg, pen_s_reg, prbs_s_reg;
	logic [2:0] prate_s1_reg, prate_s2_reg;
	logic restart_reg, restart_next;

	mgmt_frame_slave u_frame (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.mdc_i(mdc_i),
		.mdio_i(mdio_i),
		.phy_addr_i(phy_addr_i),
		.mdio_o(mdio_o),
		.mdio_oe_o(mdio_oe_o),
		.bus(bus)
	);

	dwell_timer u_dwell (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.dw(dw)
	);

	wire [1:0] ref_freq_code = ctrl_b_hi_reg[9:8];
	wire [7:0] candidate_rate_enables = ctrl_b_hi_reg[7:0]; // R2
	wire [20:0] dwell_interval = {interval_hi_reg, interval_low_reg}; // R4
	assign dw.interval = dwell_interval;
	assign dw.restart = restart_reg;

	wire lock_s = lock_s_reg[1];
	wire prbs_s = prbs_s_reg[1];
	wire own_search = search_enable_mode_reg == 2'h1 ||
		search_enable_mode_reg == 2'h2; // R11
	wire follow = search_enable_mode_reg == 2'h3 && pen_s_reg[1]; // R11

	// bit 7 is the fastest rate, so searching starts from the top
	function automatic logic [2:0] top_rate(input logic [7:0] en);
		logic [2:0] r;
		r = 3'h7;
		for (int i = 0; i < 8; i++)
			if (en[i])
				r = 3'(i); // R3
		return r;
	endfunction : top_rate

	// next enabled rate below cur, wrapping to the top when none remains
	function automatic logic [2:0] lower_rate(input logic [7:0] en,
		input logic [2:0] cur);
		logic [2:0] r;
		r = top_rate(en);
		for (int i = 0; i < 8; i++)
			if (en[i] && 3'(i) < cur)
				r = 3'(i); // R12
		return r;
	endfunction : lower_rate

	wire [2:0] rate_first = top_rate(candidate_rate_enables);
	wire [2:0] rate_lower = lower_rate(candidate_rate_enables, rate_reg);

	always_comb
	begin
		state_next = state_reg;
		rate_next = rate_reg;
		restart_next = 1'b0;
		case (state_reg)
			rate_search_pkg::S_MGMT:
				if (own_search)
				begin
					state_next = rate_search_pkg::S_DWELL;
					rate_next = rate_first;
					restart_next = 1'b1;
				end
			rate_search_pkg::S_DWELL:
				if (!own_search)
					state_next = rate_search_pkg::S_MGMT;
				else if (lock_s)
					state_next = rate_search_pkg::S_LOCK;
				// an expiry latched before the restart lands is stale
				else if (dw.expire && !restart_reg)
				begin
					rate_next = rate_lower; // R6
					restart_next = 1'b1;
				end
			rate_search_pkg::S_LOCK:
				if (!own_search)
					state_next = rate_search_pkg::S_MGMT;
				else if (!lock_s)
				begin
					state_next = rate_search_pkg::S_DWELL;
					restart_next = 1'b1;
				end
			default:
				state_next = rate_search_pkg::S_MGMT;
		endcase
	end

	// the error source follows the active mode; prbs pin or verify mode selects pattern errors over code errors
	wire err_event = (prbs_s | test_verify_en_i) ? pattern_err_i : // R8 R9
		(decoder_en_i & code_err_i); // R7
	wire err_rd = bus.rd_stb && bus.addr == `ADDR_ERROR_COUNT;
	wire [15:0] err_inc = (err_cnt_reg == 16'hffff) ? err_cnt_reg :
		err_cnt_reg + 16'h0001;
	wire wr_a = bus.wr_stb && bus.addr == `ADDR_CTRL_A;
	wire wr_b = bus.wr_stb && bus.addr == `ADDR_CTRL_B;
	wire wr_low = bus.wr_stb && bus.addr == `ADDR_INTERVAL_LOW;

	wire [15:0] ctrl_a_view = {2'h0, search_enable_mode_reg, 12'h000} |
		(`RST_CTRL_A & 16'h0fff);
	wire [15:0] ctrl_b_view = {ctrl_b_hi_reg, 1'b1, interval_hi_reg}; // R13
	wire [15:0] rd_mux =
		(bus.addr == `ADDR_CTRL_A) ? ctrl_a_view :
		(bus.addr == `ADDR_CTRL_B) ? ctrl_b_view :
		(bus.addr == `ADDR_INTERVAL_LOW) ? interval_low_reg :
		(bus.addr == `ADDR_RESERVED) ? `RST_RESERVED : // R13
		(bus.addr == `ADDR_ERROR_COUNT) ? err_cnt_reg :
		(bus.addr == `ADDR_VENDOR_STATUS) ? `RST_VENDOR_STATUS : // R13
		16'h0000;
	assign bus.rdata = rdata_reg;

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lock_s_reg <= 2'h0;
			pen_s_reg <= 2'h0;
			prbs_s_reg <= 2'h0;
			prate_s1_reg <= 3'h0;
			prate_s2_reg <= 3'h0;
		end
		else
		begin
			lock_s_reg <= {lock_s_reg[0], rate_lock_i};
			pen_s_reg <= {pen_s_reg[0], partner_search_en_i};
			prbs_s_reg <= {prbs_s_reg[0], prbs_test_pin_i};
			prate_s1_reg <= partner_rate_i;
			prate_s2_reg <= prate_s1_reg;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			search_enable_mode_reg <= 2'(`RST_CTRL_A >> `MODE_LSB);
			ctrl_b_hi_reg <= 10'(`RST_CTRL_B >> `RATE_EN_LSB);
			interval_hi_reg <= 5'(`RST_CTRL_B);
			interval_low_reg <= `RST_INTERVAL_LOW;
		end
		else
		begin
			if (wr_a)
				search_enable_mode_reg <= bus.wdata[`MODE_LSB+1:`MODE_LSB];
			if (wr_b)
			begin
				ctrl_b_hi_reg <= bus.wdata[15:`RATE_EN_LSB];
				interval_hi_reg <= bus.wdata[`INTERVAL_HI_MSB:0]; // R4
			end
			if (wr_low)
				interval_low_reg <= bus.wdata; // R4
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			err_cnt_reg <= `RST_ERROR_COUNT;
			rdata_reg <= 16'h0000;
		end
		else
		begin
			if (bus.rd_stb)
				rdata_reg <= rd_mux;
			// an error in the read cycle is kept as a count of one
			if (err_rd)
				err_cnt_reg <= {15'h0000, err_event}; // R10
			else if (err_event)
				err_cnt_reg <= err_inc;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_reg <= rate_search_pkg::S_MGMT;
			rate_reg <= 3'h7;
			restart_reg <= 1'b0;
			search_ref_freq_code_o <= 2'(`RST_CTRL_B >> `REF_FREQ_LSB);
			rate_sel_o <= 3'h7;
			mgmt_ctrl_o <= 1'b1;
			search_locked_o <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			rate_reg <= rate_next;
			restart_reg <= restart_next;
			// code 10 is reserved and passed through unchanged
			search_ref_freq_code_o <= ref_freq_code; // R1
			rate_sel_o <= follow ? prate_s2_reg : rate_next; // R11
			mgmt_ctrl_o <= ~own_search & ~follow; // R11
			search_locked_o <= state_next == rate_search_pkg::S_LOCK;
		end
	end
endmodule : rate_search_top
`default_nettype wire

// ==== rate_search_top_chk.sv ====
// Purpose: port checks for the rate search block
// Assumes: one clock, async active-low reset
// Notes: dwell length lives in registers, so only its floor is checked
`timescale 1ns/1ps
`default_nettype none
module rate_search_chk (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic rate_lock_i,
	input wire logic partner_search_en_i,
	input wire logic mdio_o,
	input wire logic mdio_oe_o,
	input wire logic [2:0] rate_sel_o,
	input wire logic mgmt_ctrl_o,
	input wire logic search_locked_o
);
	logic [2:0] rate_q_reg;
	logic [10:0] since_reg;
	logic [10:0] since_next;
	wire moved = rate_sel_o != rate_q_reg;
	wire hold = moved || mgmt_ctrl_o || search_locked_o;
	assign since_next = hold ? 11'h000 : since_reg + 11'(!(&since_reg));
	always_ff @(posedge mclk_i or negedge rst_n_i)
		if (!rst_n_i)
		begin
			rate_q_reg <= 3'h7;
			since_reg <= 11'h000;
		end
		else
		begin
			rate_q_reg <= rate_sel_o;
			since_reg <= since_next;
		end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	mgmt_hold_a: assert property (mgmt_ctrl_o && $past(mgmt_ctrl_o)
		|-> $stable(rate_sel_o)) else $error("rate moved under management");
	mgmt_nolock_a: assert property (mgmt_ctrl_o && $past(mgmt_ctrl_o)
		|-> !search_locked_o) else $error("locked under management");
	lock_src_a: assert property ($rose(search_locked_o) |->
		$past(rate_lock_i, 2) || $past(rate_lock_i, 3)) else $error("lock no cause");
	lock_drop_a: assert property (!rate_lock_i [*5] |=>
		!search_locked_o) else $error("lock kept after loss");
	lock_hold_a: assert property (search_locked_o && $past(search_locked_o)
		|-> $stable(rate_sel_o)) else $error("rate moved while locked");
	dwell_min_a: assert property (!mgmt_ctrl_o [*4] ##0 (moved &&
		!partner_search_en_i && $past(!search_locked_o)) |-> since_reg >= 11'h3fc)
		else $error("rate stepped before dwell");
	ta_zero_a: assert property ($rose(mdio_oe_o) |-> !mdio_o)
		else $error("turnaround bit not zero");
	ta_hold_a: assert property ($rose(mdio_oe_o) |-> mdio_oe_o [*8])
		else $error("read answer cut short");
	step_c: cover property (moved && !mgmt_ctrl_o);
	lock_c: cover property ($rose(search_locked_o));
	read_c: cover property ($rose(mdio_oe_o));
endmodule : rate_search_chk
bind rate_search_top rate_search_chk chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.rate_lock_i(rate_lock_i), .partner_search_en_i(partner_search_en_i),
	.mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .rate_sel_o(rate_sel_o),
	.mgmt_ctrl_o(mgmt_ctrl_o), .search_locked_o(search_locked_o));
`default_nettype wire

// ==== tb_rate_search_top.sv ====
// Purpose: self-checking bench for the rate search block
// Assumes: host model makes frames, mdc at 10 mclk per phase
// Notes: interval of 1 keeps each dwell near 1024 cycles
`timescale 1ns/1ps
`default_nettype none
`include "rate_search_params.svh"
module tb_rate_search_top;
	localparam logic [15:0] rst_vals [7] = '{16'h0800, 16'h7fff, 16'hffff,
		16'h3000, 16'hfffd, 16'h0205, 16'h0000};
	localparam logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
	localparam logic [2:0] modes [4] = '{3'b100, 3'b000, 3'b110, 3'b001};
	localparam logic [2:0] steps [3] = '{3'h5, 3'h2, 3'h6};
	logic mclk = 1'b0, rst_n = 1'b0, lock = 1'b0, pse = 1'b0, dec = 1'b0;
	logic cerr = 1'b0, ver = 1'b0, perr = 1'b0, prbs = 1'b0;
	logic [2:0] prate = 3'h0;
	logic mdc, h_d, h_oe, d_o, d_oe, locked, mgmt;
	logic [1:0] ref_code;
	logic [2:0] rate;
	logic [31:0] seed = 32'h0000004f;
	logic [15:0] rd, w;
	int n_fail = 0, checks_done = 0, cyc = 0;
	wire mdio_w = d_oe ? d_o : (h_oe ? h_d : 1'b1);
	mgmt_host_model host (.mclk_i(mclk), .mdio_i(mdio_w), .mdc_o(mdc),
		.mdio_o(h_d), .mdio_oe_o(h_oe));
	rate_search_top dut (.mclk_i(mclk), .rst_n_i(rst_n), .mdc_i(mdc),
		.mdio_i(mdio_w), .phy_addr_i(5'h05), .rate_lock_i(lock),
		.partner_search_en_i(pse), .partner_rate_i(prate), .decoder_en_i(dec),
		.code_err_i(cerr), .test_verify_en_i(ver), .pattern_err_i(perr),
		.prbs_test_pin_i(prbs), .mdio_o(d_o), .mdio_oe_o(d_oe),
		.search_ref_freq_code_o(ref_code), .rate_sel_o(rate),
		.mgmt_ctrl_o(mgmt), .search_locked_o(locked));
	initial
	begin
		forever #2.5 mclk = ~mclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic [15:0] b_read(input logic [15:0] v);
		return {v[15:6], 1'b1, v[4:0]};
	endfunction : b_read
	// pattern errors win whenever either test mode is on
	function automatic int err_hit(input logic d, v, p, c, e);
		return (p || v) ? int'(e) : int'(d && c);
	endfunction : err_hit
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		host.frame(`OP_WRITE, a, d, rd);
		tick(2);
	endtask : wr
	task automatic rd_reg(input logic [4:0] a);
		host.frame(`OP_READ, a, 16'h0000, rd);
	endtask : rd_reg
	task automatic wait_chg(output int dt);
		logic [2:0] was;
		was = rate;
		dt = 0;
		while (rate === was && dt < 3000)
		begin
			tick(1);
			dt++;
		end
	endtask : wait_chg
	task automatic conclude;
		$display("counts: checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_fail++;
			conclude;
		end
	end
	initial
	begin
		int dt;
		int n;
		tick(3);
		chk(16'({ref_code, rate, mgmt, locked, d_oe}), 16'h007c);
		tick(1);
		rst_n = 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			rd_reg(5'h0a + 5'(i));
			chk(rd, rst_vals[i]);
		end
		seed = xs(seed);
		wr(`ADDR_RESERVED, seed[15:0]);
		wr(`ADDR_VENDOR_STATUS, seed[31:16]);
		wr(`ADDR_ERROR_COUNT, seed[15:0]);
		rd_reg(`ADDR_RESERVED);
		chk(rd, `RST_RESERVED);
		rd_reg(`ADDR_VENDOR_STATUS);
		chk(rd, `RST_VENDOR_STATUS);
		rd_reg(`ADDR_ERROR_COUNT);
		chk(rd, 16'h0000);
		for (int i = 0; i < 3; i++)
		begin
			seed = xs(seed);
			w = {codes[i], seed[13:0]};
			wr(`ADDR_CTRL_B, w);
			chk(16'(ref_code), 16'(codes[i]));
			rd_reg(`ADDR_CTRL_B);
			chk(rd, b_read(w));
		end
		wr(`ADDR_INTERVAL_LOW, seed[31:16]);
		rd_reg(`ADDR_INTERVAL_LOW);
		chk(rd, seed[31:16]);
		$display("test registers done");
		for (int m = 0; m < 4; m++)
		begin
			{dec, ver, prbs} = modes[m];
			n = 0;
			tick(4);
			repeat (64)
			begin
				seed = xs(seed);
				{cerr, perr} = seed[1:0];
				tick(1);
				n += err_hit(dec, ver, prbs, cerr, perr);
			end
			{cerr, perr} = 2'b00;
			tick(2);
			rd_reg(`ADDR_ERROR_COUNT);
			chk(rd, 16'(n));
		end
		{dec, ver, prbs} = 3'b000;
		$display("test errors done");
		// enables 6, 5 and 2 so the walk skips holes and wraps
		wr(`ADDR_INTERVAL_LOW, 16'h0001);
		wr(`ADDR_CTRL_B, 16'h5900);
		wr(`ADDR_CTRL_A, 16'h1000);
		chk(16'({rate, mgmt}), 16'h000c);
		for (int k = 0; k < 3; k++)
		begin
			wait_chg(dt);
			chk(16'(rate), 16'(steps[k]));
			if (k > 0)
				chk(16'(dt >= 1024 && dt <= 1030), 16'h0001);
		end
		lock = 1'b1;
		tick(6);
		chk(16'(locked), 16'h0001);
		tick(1500);
		chk(16'(rate), 16'h0006);
		lock = 1'b0;
		wait_chg(dt);
		chk(16'({rate, locked}), 16'h000a);
		wr(`ADDR_CTRL_A, 16'h0000);
		chk(16'(mgmt), 16'h0001);
		wr(`ADDR_CTRL_A, 16'h2000);
		chk(16'({rate, mgmt}), 16'h000c);
		pse = 1'b1;
		wr(`ADDR_CTRL_A, 16'h3000);
		repeat (3)
		begin
			seed = xs(seed);
			prate = seed[2:0];
			tick(6);
			chk(16'({rate, mgmt}), 16'({prate, 1'b0}));
		end
		pse = 1'b0;
		tick(6);
		chk(16'(mgmt), 16'h0001);
		$display("test search done");
		conclude;
	end
endmodule : tb_rate_search_top
`default_nettype wire
